// ==== hw/asrc_top.v ====
// Auto-sleep rate control: power mode, sample rate and sleep/wake sequencing.
// Assumes register accesses and event strobes come from logic on i_ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "asrc_consts.vh"

module asrc_top
#(
  parameter BASE_CYCLES = `ASRC_BASE_CYCLES
)
(
  // Clock and reset.
  input  wire       i_ref_clk,
  input  wire       i_srst,
  // Register access.
  input  wire [7:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire [7:0] i_reg_wdata,
  input  wire       i_reg_rd,
  output reg  [7:0] o_reg_rdata,
  output reg        o_reg_rvalid,
  // Settings held by neighbouring registers.
  input  wire       i_fifo_gate_en,
  input  wire [3:0] i_wake_source_config,
  input  wire [3:0] i_interrupt_enable_config,
  input  wire       i_sleep_int_en,
  // Event strobes from the detection functions and FIFO.
  input  wire       i_transient_source,
  input  wire       i_orientation_source,
  input  wire       i_tap_source,
  input  wire       i_freefall_motion_source,
  input  wire       i_fifo_gate_evt,
  input  wire       i_fifo_empty,
  // Mode and rate outputs.
  output wire       o_active,
  output wire       o_sleeping,
  output wire [2:0] o_output_sample_rate,
  output wire       o_func_tick,
  output wire [1:0] o_oversample_mode,
  output wire       o_quiet_range_mode,
  output wire       o_fast_read,
  output wire       o_diag_shift_enable,
  output wire       o_soft_reset,
  // Sleep transition event and interrupt.
  output reg        o_sleep_transition_source,
  output reg        o_sleep_irq,
  // FIFO control.
  output wire       o_fifo_store_en,
  output reg        o_fifo_flush,
  output reg        o_fifo_gate_err
);

  localparam [1:0] ST_STANDBY = 2'h0;
  localparam [1:0] ST_WAKE    = 2'h1;
  localparam [1:0] ST_SLEEP   = 2'h2;

  reg  [7:0] inactivity_duration_reg;
  reg  [1:0] sleep_rate_select_reg;
  reg  [2:0] output_rate_code_reg;
  reg        quiet_range_mode_reg;
  reg        fast_read_reg;
  reg        active_reg;
  reg        diag_shift_enable_reg;
  reg        soft_reset_reg;
  reg  [1:0] sleep_oversample_mode_reg;
  reg        auto_sleep_enable_reg;
  reg  [1:0] wake_oversample_mode_reg;
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg        hold_reg;
  reg        hold_next;
  reg        gate_err_next;
  reg  [7:0] rdata_next;

  wire       rst_all;
  wire       base_tick;
  wire       odr_tick;
  wire       expired;
  wire       timer_run;
  wire       restart;
  wire       wake_evt;
  wire       rate_change;
  wire [3:0] func_evt;
  wire [2:0] eff_rate;
  wire       wr_ctrl_two;

  // Map the sleep-rate field onto the equivalent data-rate code.
  function [2:0] sleep_rate_code;
    input [1:0] sel;
    begin
      sleep_rate_code = {`ASRC_SLEEP_RATE_BASE, sel};
    end
  endfunction

  // A soft reset takes effect on the cycle after the write.
  assign rst_all     = i_srst || soft_reset_reg;
  assign wr_ctrl_two = i_reg_wr && (i_reg_addr == `ASRC_ADDR_SYS_CTRL_TWO);

  assign func_evt = {i_transient_source, i_orientation_source,
                     i_tap_source, i_freefall_motion_source}
                    & i_interrupt_enable_config;
  // Sleep-transition and sample-ready strobes are deliberately not inputs here.
  assign restart  = (|func_evt) || i_fifo_gate_evt;
  assign wake_evt = |(func_evt & i_wake_source_config);

  assign timer_run = (state_reg == ST_WAKE) && auto_sleep_enable_reg;

  assign eff_rate = (state_reg == ST_SLEEP) ? sleep_rate_code(sleep_rate_select_reg)
                                            : output_rate_code_reg;

  assign rate_change = ((state_reg == ST_WAKE) && (state_next == ST_SLEEP)) ||
                       ((state_reg == ST_SLEEP) && (state_next == ST_WAKE));

  assign o_active             = active_reg;
  assign o_sleeping           = (state_reg == ST_SLEEP);
  assign o_output_sample_rate = eff_rate;
  assign o_func_tick          = odr_tick;
  assign o_oversample_mode    = (state_reg == ST_SLEEP) ? sleep_oversample_mode_reg
                                                        : wake_oversample_mode_reg;
  assign o_quiet_range_mode   = quiet_range_mode_reg;
  assign o_fast_read          = fast_read_reg;
  assign o_diag_shift_enable  = diag_shift_enable_reg;
  assign o_soft_reset         = soft_reset_reg;
  assign o_fifo_store_en      = odr_tick && !hold_reg && (state_reg != ST_STANDBY);

  asrc_odr_tick
  #(
    .BASE_CYCLES (BASE_CYCLES)
  )
  u_odr_tick
  (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (rst_all),
    .i_run       (active_reg),
    .i_rate_code (eff_rate),
    .o_base_tick (base_tick),
    .o_odr_tick  (odr_tick)
  );

  asrc_inact_timer u_inact_timer
  (
    .i_ref_clk   (i_ref_clk),
    .i_srst      (rst_all),
    .i_run       (timer_run),
    .i_restart   (restart),
    .i_slow_unit (output_rate_code_reg == `ASRC_RATE_SLOWEST),
    .i_duration  (inactivity_duration_reg),
    .i_base_tick (base_tick),
    .o_expired   (expired)
  );

  // Power mode sequencing.
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_STANDBY:
      begin
        if (active_reg)
        begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        if (!active_reg)
        begin
          state_next = ST_STANDBY;
        end
        else if (auto_sleep_enable_reg && expired && !restart)
        begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (!active_reg)
        begin
          state_next = ST_STANDBY;
        end
        else if (wake_evt || !auto_sleep_enable_reg)
        begin
          state_next = ST_WAKE;
        end
      end
      default:
      begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  // FIFO hold and gate error; a new hold wins over a same-cycle empty, but an empty blocks a new error.
  always @*
  begin
    hold_next     = hold_reg;
    gate_err_next = o_fifo_gate_err;
    if (i_fifo_empty)
    begin
      hold_next     = 1'b0;
      gate_err_next = 1'b0;
    end
    if (i_fifo_gate_en && rate_change)
    begin
      hold_next = 1'b1;
    end
    if (hold_reg && odr_tick && !i_fifo_empty)
    begin
      gate_err_next = 1'b1;
    end
  end

  // Register read mux; undecoded addresses read as zero.
  always @*
  begin
    case (i_reg_addr)
      `ASRC_ADDR_INACT_DUR:
      begin
        rdata_next = inactivity_duration_reg;
      end
      `ASRC_ADDR_SYS_CTRL_ONE:
      begin
        rdata_next = {sleep_rate_select_reg, output_rate_code_reg,
                      quiet_range_mode_reg, fast_read_reg, active_reg};
      end
      `ASRC_ADDR_SYS_CTRL_TWO:
      begin
        rdata_next = {diag_shift_enable_reg, 1'b0, 1'b0, sleep_oversample_mode_reg,
                      auto_sleep_enable_reg, wake_oversample_mode_reg};
      end
      default:
      begin
        rdata_next = `ASRC_READ_ZERO;
      end
    endcase
  end

  // Register writes.
  always @(posedge i_ref_clk)
  begin
    if (rst_all)
    begin
      inactivity_duration_reg   <= `ASRC_RESET_BYTE;
      sleep_rate_select_reg     <= 2'h0;
      output_rate_code_reg      <= 3'h0;
      quiet_range_mode_reg      <= 1'b0;
      fast_read_reg             <= 1'b0;
      active_reg                <= 1'b0;
      diag_shift_enable_reg     <= 1'b0;
      soft_reset_reg            <= 1'b0;
      sleep_oversample_mode_reg <= 2'h0;
      auto_sleep_enable_reg     <= 1'b0;
      wake_oversample_mode_reg  <= 2'h0;
    end
    else
    begin
      if (i_reg_wr && (i_reg_addr == `ASRC_ADDR_INACT_DUR))
      begin
        inactivity_duration_reg <= i_reg_wdata;
      end
      if (i_reg_wr && (i_reg_addr == `ASRC_ADDR_SYS_CTRL_ONE))
      begin
        sleep_rate_select_reg <= i_reg_wdata[`ASRC_C1_SLEEP_RATE_HI:`ASRC_C1_SLEEP_RATE_LO];
        output_rate_code_reg  <= i_reg_wdata[`ASRC_C1_RATE_HI:`ASRC_C1_RATE_LO];
        quiet_range_mode_reg  <= i_reg_wdata[`ASRC_C1_QUIET];
        fast_read_reg         <= i_reg_wdata[`ASRC_C1_FAST_READ];
        active_reg            <= i_reg_wdata[`ASRC_C1_ACTIVE];
      end
      if (wr_ctrl_two)
      begin
        diag_shift_enable_reg     <= i_reg_wdata[`ASRC_C2_DIAG];
        soft_reset_reg            <= i_reg_wdata[`ASRC_C2_SOFT_RESET];
        sleep_oversample_mode_reg <= i_reg_wdata[`ASRC_C2_SLEEP_OS_HI:`ASRC_C2_SLEEP_OS_LO];
        auto_sleep_enable_reg     <= i_reg_wdata[`ASRC_C2_AUTO_SLEEP];
        wake_oversample_mode_reg  <= i_reg_wdata[`ASRC_C2_WAKE_OS_HI:`ASRC_C2_WAKE_OS_LO];
      end
    end
  end

  // Mode state, transition events and read data.
  always @(posedge i_ref_clk)
  begin
    if (rst_all)
    begin
      state_reg                 <= ST_STANDBY;
      hold_reg                  <= 1'b0;
      o_fifo_gate_err           <= 1'b0;
      o_fifo_flush              <= 1'b0;
      o_sleep_transition_source <= 1'b0;
      o_sleep_irq               <= 1'b0;
      o_reg_rdata               <= `ASRC_READ_ZERO;
      o_reg_rvalid              <= 1'b0;
    end
    else
    begin
      state_reg                 <= state_next;
      hold_reg                  <= hold_next;
      o_fifo_gate_err           <= gate_err_next;
      // Without the gate the FIFO is flushed on every rate change.
      o_fifo_flush              <= rate_change && !i_fifo_gate_en;
      o_sleep_transition_source <= rate_change;
      o_sleep_irq               <= rate_change && i_sleep_int_en;
      o_reg_rvalid              <= i_reg_rd;
      if (i_reg_rd)
      begin
        o_reg_rdata <= rdata_next;
      end
    end
  end

endmodule
`default_nettype wire

// ==== shared/asrc_consts.vh ====
// Constants for the auto-sleep rate control block.
// Assumes a 40 MHz reference clock and byte-wide register access.
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH

`define ASRC_CLK_PERIOD_NS        25
`define ASRC_ODR_BASE_PERIOD_NS   1250000
`define ASRC_BASE_CYCLES          (`ASRC_ODR_BASE_PERIOD_NS / `ASRC_CLK_PERIOD_NS)
`define ASRC_INACT_STEP_NS        320000000
`define ASRC_INACT_STEP_SLOW_NS   640000000
`define ASRC_INACT_STEP_TICKS     (`ASRC_INACT_STEP_NS / `ASRC_ODR_BASE_PERIOD_NS)
`define ASRC_INACT_SLOW_TICKS     (`ASRC_INACT_STEP_SLOW_NS / `ASRC_ODR_BASE_PERIOD_NS)

`define ASRC_ADDR_INACT_DUR       8'h29
`define ASRC_ADDR_SYS_CTRL_ONE    8'h2A
`define ASRC_ADDR_SYS_CTRL_TWO    8'h2B
`define ASRC_RESET_BYTE           8'h00
`define ASRC_READ_ZERO            8'h00

`define ASRC_C1_SLEEP_RATE_HI     7
`define ASRC_C1_SLEEP_RATE_LO     6
`define ASRC_C1_RATE_HI           5
`define ASRC_C1_RATE_LO           3
`define ASRC_C1_QUIET             2
`define ASRC_C1_FAST_READ         1
`define ASRC_C1_ACTIVE            0
`define ASRC_C2_DIAG              7
`define ASRC_C2_SOFT_RESET        6
`define ASRC_C2_SLEEP_OS_HI       4
`define ASRC_C2_SLEEP_OS_LO       3
`define ASRC_C2_AUTO_SLEEP        2
`define ASRC_C2_WAKE_OS_HI        1
`define ASRC_C2_WAKE_OS_LO        0

`define ASRC_RATE_SLOWEST         3'h7
`define ASRC_SLEEP_RATE_BASE      1'h1

`define ASRC_DIV_800              10'h001
`define ASRC_DIV_400              10'h002
`define ASRC_DIV_200              10'h004
`define ASRC_DIV_100              10'h008
`define ASRC_DIV_50               10'h010
`define ASRC_DIV_12P5             10'h040
`define ASRC_DIV_6P25             10'h080
`define ASRC_DIV_1P56             10'h200

`endif

// ==== hw/asrc_odr_tick.v ====
// Output data rate tick generator: base 1.25 ms tick and rate-scaled sample tick.
// Assumes the rate code input is already the effective (wake or sleep) code.
`timescale 1ns/100ps
`default_nettype none
`include "asrc_consts.vh"

module asrc_odr_tick
#(
  parameter BASE_CYCLES = `ASRC_BASE_CYCLES,
  parameter CW          = 24
)
(
  // Clock and reset.
  input  wire       i_ref_clk,
  input  wire       i_srst,
  // Control.
  input  wire       i_run,
  input  wire [2:0] i_rate_code,
  // Ticks.
  output reg        o_base_tick,
  output reg        o_odr_tick
);

  reg  [CW-1:0] cyc_reg;
  reg  [9:0]    div_reg;
  wire [9:0]    div_len;
  wire          base_end;

  // Number of 1.25 ms base ticks in one sample period.
  function [9:0] rate_div;
    input [2:0] code;
    begin
      case (code)
        3'h0:    rate_div = `ASRC_DIV_800;
        3'h1:    rate_div = `ASRC_DIV_400;
        3'h2:    rate_div = `ASRC_DIV_200;
        3'h3:    rate_div = `ASRC_DIV_100;
        3'h4:    rate_div = `ASRC_DIV_50;
        3'h5:    rate_div = `ASRC_DIV_12P5;
        3'h6:    rate_div = `ASRC_DIV_6P25;
        default: rate_div = `ASRC_DIV_1P56;
      endcase
    end
  endfunction

  assign div_len  = rate_div(i_rate_code);
  assign base_end = (cyc_reg == BASE_CYCLES[CW-1:0] - 1'b1);

  always @(posedge i_ref_clk)
  begin
    if (i_srst || !i_run)
    begin
      cyc_reg     <= {CW{1'b0}};
      div_reg     <= 10'h000;
      o_base_tick <= 1'b0;
      o_odr_tick  <= 1'b0;
    end
    else
    begin
      o_base_tick <= base_end;
      o_odr_tick  <= 1'b0;
      if (base_end)
      begin
        cyc_reg <= {CW{1'b0}};
        // A shortened rate restarts the period rather than overrunning it.
        if (div_reg + 10'h001 >= div_len)
        begin
          div_reg    <= 10'h000;
          o_odr_tick <= 1'b1;
        end
        else
        begin
          div_reg <= div_reg + 10'h001;
        end
      end
      else
      begin
        cyc_reg <= cyc_reg + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/asrc_inact_timer.v ====
// Inactivity timer counting duration units of base ticks.
// Assumes one-cycle base ticks from the rate tick generator.
`timescale 1ns/100ps
`default_nettype none
`include "asrc_consts.vh"

module asrc_inact_timer
(
  // Clock and reset.
  input  wire       i_ref_clk,
  input  wire       i_srst,
  // Control.
  input  wire       i_run,
  input  wire       i_restart,
  input  wire       i_slow_unit,
  input  wire [7:0] i_duration,
  input  wire       i_base_tick,
  // Status.
  output wire       o_expired
);

  localparam integer UNIT_FAST_I = `ASRC_INACT_STEP_TICKS;
  localparam integer UNIT_SLOW_I = `ASRC_INACT_SLOW_TICKS;
  localparam [9:0]   UNIT_FAST   = UNIT_FAST_I[9:0];
  localparam [9:0]   UNIT_SLOW   = UNIT_SLOW_I[9:0];

  reg  [9:0] sub_reg;
  reg  [7:0] unit_reg;
  wire [9:0] unit_len;

  assign unit_len  = i_slow_unit ? UNIT_SLOW : UNIT_FAST;
  assign o_expired = i_run && (unit_reg >= i_duration);

  always @(posedge i_ref_clk)
  begin
    if (i_srst || !i_run || i_restart)
    begin
      sub_reg  <= 10'h000;
      unit_reg <= 8'h00;
    end
    else if (i_base_tick && !o_expired)
    begin
      if (sub_reg + 10'h001 >= unit_len)
      begin
        sub_reg  <= 10'h000;
        unit_reg <= unit_reg + 8'h01;
      end
      else
      begin
        sub_reg <= sub_reg + 10'h001;
      end
    end
  end

endmodule
`default_nettype wire

// ==== dv/asrc_top_assertions.sv ====
// Concurrent checks on the auto-sleep rate control top level.
// Assumes one clock and register writes that land at the next edge.
`timescale 1ns/100ps
`default_nettype none
module asrc_top_assertions
#(
  parameter BASE_CYCLES = 50000
)
(
  // Clock, reset and register port.
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_rd,
  input wire logic       o_reg_rvalid,
  // Events and neighbour settings.
  input wire logic [3:0] i_wake_source_config,
  input wire logic [3:0] i_interrupt_enable_config,
  input wire logic       i_transient_source,
  input wire logic       i_orientation_source,
  input wire logic       i_tap_source,
  input wire logic       i_freefall_motion_source,
  input wire logic       i_fifo_gate_evt,
  input wire logic       i_fifo_gate_en,
  input wire logic       i_fifo_empty,
  // Observed outputs.
  input wire logic       o_active,
  input wire logic       o_sleeping,
  input wire logic [2:0] o_output_sample_rate,
  input wire logic [1:0] o_oversample_mode,
  input wire logic       o_quiet_range_mode,
  input wire logic       o_soft_reset,
  input wire logic       o_sleep_transition_source,
  input wire logic       o_sleep_irq,
  input wire logic       o_fifo_store_en,
  input wire logic       o_fifo_gate_err
);
  logic [7:0]      one_sh;
  logic [7:0]      two_sh;
  wire logic [3:0] evts = {i_transient_source, i_orientation_source, i_tap_source,
                           i_freefall_motion_source};
  wire logic       hit  = |(evts & i_wake_source_config & i_interrupt_enable_config);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // Control bytes as the host last wrote them; soft reset wipes them.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || o_soft_reset)
    begin
      one_sh <= 8'h00;
      two_sh <= 8'h00;
    end
    else if (i_reg_wr && i_reg_addr == 8'h2A)
      one_sh <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == 8'h2B)
      two_sh <= i_reg_wdata;
  end
  sequence s_rst_pulse;
    o_soft_reset ##1 !o_soft_reset;
  endsequence
  sequence s_flip;
    $changed(o_sleeping) && o_active && !$past(o_soft_reset);
  endsequence
  chk_read_answer: assert property (i_reg_rd && !o_soft_reset |=> o_reg_rvalid)
    else $error("read strobe not answered");
  chk_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without a read");
  chk_active_bit: assert property (o_active == one_sh[0])
    else $error("active output differs from control one");
  chk_wake_rate: assert property (!o_sleeping |-> o_output_sample_rate == one_sh[5:3])
    else $error("wake rate differs from rate field");
  chk_sleep_rate: assert property (o_sleeping |-> o_output_sample_rate == {1'b1, one_sh[7:6]})
    else $error("sleep rate differs from sleep field");
  chk_os_mode: assert property (o_oversample_mode == (o_sleeping ? two_sh[4:3] : two_sh[1:0]))
    else $error("oversample mode field not followed");
  chk_quiet_bit: assert property (o_quiet_range_mode == one_sh[2])
    else $error("quiet range output differs");
  chk_flip_pulse: assert property (s_flip |-> o_sleep_transition_source)
    else $error("no pulse after a sleep change");
  chk_irq_cause: assert property (o_sleep_irq |-> o_sleep_transition_source)
    else $error("sleep interrupt without transition");
  chk_soft_pulse: assert property (i_reg_wr && i_reg_addr == 8'h2B && i_reg_wdata[6]
    && !o_soft_reset |=> s_rst_pulse)
    else $error("soft reset pulse wrong");
  chk_fifo_no_wake: assert property (o_sleeping && o_active && i_fifo_gate_evt && !hit
    && two_sh[2] && !i_reg_wr && !o_soft_reset |=> o_sleeping)
    else $error("gate event woke the device");
  chk_event_wake: assert property (o_sleeping && o_active && hit |=> !o_sleeping)
    else $error("enabled wake event ignored");
  chk_no_autosleep: assert property (!two_sh[2] && !$past(two_sh[2]) |-> !o_sleeping)
    else $error("asleep with auto-sleep off");
  chk_gate_hold: assert property ($changed(o_sleeping) && o_active && $past(i_fifo_gate_en)
    |-> !o_fifo_store_en)
    else $error("sample stored right after a gated rate change");
  chk_gate_err_clear: assert property (o_fifo_gate_err && i_fifo_empty |=> !o_fifo_gate_err)
    else $error("gate error kept after empty");
endmodule
bind asrc_top asrc_top_assertions #(.BASE_CYCLES(BASE_CYCLES)) u_chk (.i_ref_clk, .i_srst,
  .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rvalid, .i_wake_source_config,
  .i_interrupt_enable_config, .i_transient_source, .i_orientation_source, .i_tap_source,
  .i_freefall_motion_source, .i_fifo_gate_evt, .i_fifo_gate_en, .i_fifo_empty, .o_active,
  .o_sleeping, .o_output_sample_rate, .o_oversample_mode, .o_quiet_range_mode,
  .o_soft_reset, .o_sleep_transition_source, .o_sleep_irq, .o_fifo_store_en,
  .o_fifo_gate_err);
`default_nettype wire

// ==== dv/asrc_host_model.sv ====
// Host side of the register port: single byte writes and reads.
// Assumes the block answers a read one cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none
module asrc_host_model
(
  // Clock.
  input  wire logic       i_ref_clk,
  // Register port toward the block.
  output var  logic [7:0] o_reg_addr,
  output var  logic       o_reg_wr,
  output var  logic [7:0] o_reg_wdata,
  output var  logic       o_reg_rd,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reg_rvalid
);
  initial
  begin
    {o_reg_addr, o_reg_wdata, o_reg_wr, o_reg_rd} = 18'h00000;
  end
  // Idle address and data show changed values so stale bytes are never reused.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1;
    {o_reg_addr, o_reg_wdata, o_reg_wr} = {a, d, 1'b1};
    @(posedge i_ref_clk);
    #1;
    {o_reg_addr, o_reg_wdata, o_reg_wr} = {~a, ~d, 1'b0};
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge i_ref_clk);
    #1;
    {o_reg_addr, o_reg_rd} = {a, 1'b1};
    @(posedge i_ref_clk);
    #1;
    {o_reg_addr, o_reg_rd} = {~a, 1'b0};
    v = i_reg_rvalid;
    d = i_reg_rdata;
  endtask
  // Control one is only changed from standby; the active bit is cleared first and written last.
  task automatic wr_ctrl_one(input logic [7:0] d);
    logic [7:0] cur;
    logic       ok;
    rd_reg(8'h2A, cur, ok);
    wr_reg(8'h2A, cur & 8'hFE);
    wr_reg(8'h2A, d & 8'hFE);
    wr_reg(8'h2A, d);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the auto-sleep rate control block.
// Assumes a two-cycle base tick, so one inactivity unit is 512 cycles.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int B = 2;
  localparam int UNIT = 256 * B;
  logic i_ref_clk, i_srst, i_reg_wr, i_reg_rd, o_reg_rvalid, i_fifo_gate_en, i_sleep_int_en;
  logic i_transient_source, i_orientation_source, i_tap_source, i_freefall_motion_source;
  logic i_fifo_gate_evt, i_fifo_empty, o_active, o_sleeping, o_func_tick, o_quiet_range_mode;
  logic o_fast_read, o_diag_shift_enable, o_soft_reset, o_sleep_transition_source;
  logic o_sleep_irq, o_fifo_store_en, o_fifo_flush, o_fifo_gate_err, v;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, d;
  logic [3:0]  i_wake_source_config, i_interrupt_enable_config;
  logic [2:0]  o_output_sample_rate;
  logic [1:0]  o_oversample_mode;
  // Bits 29:28 hold the expected diagnostic shift and fast read outputs.
  logic [29:0] rows [7] = '{30'h029A5A50, 30'h02AF4F4E, 30'h22BBF9FE, 30'h2305A00E,
                            30'h32A02020, 30'h12B00000, 30'h12900000};
  int          mismatches, n_compared, stores, flushes, n, ticks;
  asrc_top #(.BASE_CYCLES(B)) dut (.*);
  asrc_host_model host (.i_ref_clk, .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd), .i_reg_rdata(o_reg_rdata),
    .i_reg_rvalid(o_reg_rvalid));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bit 4 is the gate event, bits 3:0 the four detection events.
  task automatic pulse(input logic [4:0] p);
    @(posedge i_ref_clk);
    #1;
    {i_fifo_gate_evt, i_transient_source, i_orientation_source, i_tap_source,
     i_freefall_motion_source} = p;
    @(posedge i_ref_clk);
    #1;
    {i_fifo_gate_evt, i_transient_source, i_orientation_source, i_tap_source,
     i_freefall_motion_source} = 5'h00;
  endtask
  task automatic wait_mode(input logic want, output int cnt);
    cnt = 0;
    while (o_sleeping !== want && cnt < 4 * UNIT)
    begin
      @(posedge i_ref_clk);
      #1;
      cnt++;
    end
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk)
  begin
    if (o_fifo_store_en === 1'b1)
      stores++;
    if (o_fifo_flush === 1'b1)
      flushes++;
    if (o_func_tick === 1'b1)
      ticks++;
  end
  initial
  begin
    #(25 * 40000);
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    i_srst = 1'b1;
    {i_fifo_gate_en, i_sleep_int_en, i_fifo_empty} = 3'h2;
    {i_wake_source_config, i_interrupt_enable_config} = 8'hF0;
    {i_fifo_gate_evt, i_transient_source, i_orientation_source, i_tap_source,
     i_freefall_motion_source} = 5'h00;
    repeat (6) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      host.rd_reg(8'h29 + i[7:0], d, v);
      check("reset value", d, 8'h00);
    end
    foreach (rows[i])
    begin
      host.wr_reg(rows[i][27:20], rows[i][19:12]);
      host.rd_reg(rows[i][27:20], d, v);
      check("read data", d, rows[i][11:4]);
      check("read valid", v, 8'h01);
      check("quiet and rate", {o_quiet_range_mode, o_output_sample_rate}, rows[i][3:0]);
      check("diag and fast", {o_diag_shift_enable, o_fast_read}, rows[i][29:28]);
    end
    host.wr_reg(8'h29, 8'h01);
    host.wr_reg(8'h2B, 8'h0E);
    host.wr_ctrl_one(8'h41);
    check("wake oversample", o_oversample_mode, 8'h02);
    repeat (UNIT / 2) @(posedge i_ref_clk);
    pulse(5'h10);
    wait_mode(1'b1, n);
    check("restarted span", n >= UNIT - 2 * B && n <= UNIT + 4 * B, 8'h01);
    check("sleep rate", o_output_sample_rate, 8'h05);
    check("sleep oversample", o_oversample_mode, 8'h01);
    check("sleep irq", {o_sleep_transition_source, o_sleep_irq}, 8'h03);
    @(posedge i_ref_clk);
    #1;
    check("sleep irq ended", {o_sleep_transition_source, o_sleep_irq}, 8'h00);
    pulse(5'h02);
    pulse(5'h10);
    check("still asleep", o_sleeping, 8'h01);
    i_interrupt_enable_config = 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      pulse(5'h01 << i);
      check("woken", o_sleeping, 8'h00);
      wait_mode(1'b1, n);
    end
    check("flush seen", flushes != 0, 8'h01);
    {i_fifo_gate_en, i_fifo_empty} = 2'h2;
    pulse(5'h01);
    stores = 0;
    ticks = 0;
    repeat (400) @(posedge i_ref_clk);
    #1;
    check("held stores", stores != 0, 8'h00);
    check("wake tick count", ticks >= 400 / B - 1 && ticks <= 400 / B + 1, 8'h01);
    check("gate error", o_fifo_gate_err, 8'h01);
    {i_fifo_gate_en, i_fifo_empty} = 2'h1;
    repeat (20) @(posedge i_ref_clk);
    #1;
    check("resumed stores", stores != 0, 8'h01);
    check("gate error cleared", o_fifo_gate_err, 8'h00);
    host.wr_ctrl_one(8'h39);
    wait_mode(1'b1, n);
    check("slow span", n >= 2 * UNIT - 2 * B && n <= 2 * UNIT + 4 * B, 8'h01);
    check("sleep rate slow", o_output_sample_rate, 8'h04);
    host.wr_reg(8'h2B, 8'h00);
    repeat (3 * UNIT) @(posedge i_ref_clk);
    #1;
    check("never asleep", o_sleeping, 8'h00);
    host.wr_reg(8'h2B, 8'h40);
    check("soft reset high", o_soft_reset, 8'h01);
    @(posedge i_ref_clk);
    #1;
    check("defaults", {o_soft_reset, o_active}, 8'h00);
    host.rd_reg(8'h2A, d, v);
    check("control one default", d, 8'h00);
    host.rd_reg(8'h2B, d, v);
    check("control two default", d, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
